// file: design/jmfw_mailbox_top.sv
// Test-port mailbox that feeds words to an internal flash write engine.
`timescale 1ns/10ps
module jmfw_mailbox_top (
	// Core clock and reset.
	input wire logic i_clk,
	input wire logic i_resetn,
	// Test port link, all on the test clock.
	input wire logic i_tck,
	input wire logic i_tdi,
	input wire logic i_dr_capture,
	input wire logic i_dr_shift,
	input wire logic i_dr_update,
	input wire logic i_mailbox_exchange_instruction,
	output logic o_tdo,
	// Execution control pins.
	input wire logic i_under_test_ctrl,
	input wire logic i_cpu_test_clock,
	// Write code parameters.
	input wire logic i_start,
	input wire logic [15:0] i_first_write_address,
	input wire logic [15:0] i_word_count,
	input wire logic [15:0] i_flash_control_word_three,
	// Flash write port and status.
	output logic o_flash_wr,
	output jmfw_pkg::jmfw_flash_req_s o_flash_req,
	output logic [15:0] o_flash_control_word_three,
	output logic o_cpu_clk_en,
	output logic o_ftg_tick,
	output logic o_busy,
	output logic o_parked,
	output logic [15:0] o_words_left
);
	import jmfw_pkg::*;

	jmfw_core_s c_ff;
	jmfw_core_s nxt_c;
	jmfw_link_s l_ff;
	jmfw_link_s nxt_l;
	logic step;
	logic ctrl_s;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [15:0] fifo_out_data;
	logic link_idle;
	logic push_word;

	// Word buffer between the mailbox and the engine; a stalled engine fills it.
	jmfw_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) i_jmfw_fifo (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_in_valid(c_ff.pend),
		.o_in_ready(fifo_in_ready),
		.i_in_data(c_ff.pend_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fifo_out_data)
	);

	assign ctrl_s = c_ff.ctrl_sync[1];
	assign step = ctrl_s ? (c_ff.cpu_test_clock_sync[1] & ~c_ff.cpu_test_clock_sync[2]) : 1'b1;
	assign fifo_out_ready = step & (c_ff.st == ST_FETCH);

	always_comb begin
		nxt_c = c_ff;
		nxt_c.wr = 1'b0;
		nxt_c.ctrl_sync = {c_ff.ctrl_sync[0], i_under_test_ctrl};
		nxt_c.cpu_test_clock_sync = {c_ff.cpu_test_clock_sync[1:0], i_cpu_test_clock};
		nxt_c.req_sync = {c_ff.req_sync[0], l_ff.req};
		// The flash timer ticks from the core clock alone, whatever the test clock does.
		if (c_ff.ftg_cnt == CNT_W'(FTG_CYC - 1)) begin
			nxt_c.ftg_cnt = '0;
			nxt_c.ftg_tick = 1'b1;
		end else begin
			nxt_c.ftg_cnt = c_ff.ftg_cnt + CNT_W'(1);
			nxt_c.ftg_tick = 1'b0;
		end
		if (c_ff.ftg_tick && c_ff.tmr != '0) begin
			nxt_c.tmr = c_ff.tmr - CNT_W'(1);
		end
		// A fresh mailbox word is held until the buffer has room.
		if (c_ff.pend && fifo_in_ready) begin
			nxt_c.pend = 1'b0;
			nxt_c.ack = ~c_ff.ack;
		end else if (!c_ff.pend && c_ff.req_sync[1] != c_ff.req_seen) begin
			nxt_c.pend = 1'b1;
			nxt_c.pend_data = l_ff.hold;
			nxt_c.req_seen = c_ff.req_sync[1];
		end
		case (c_ff.st)
			ST_IDLE: begin
				if (i_start) begin
					nxt_c.addr = i_first_write_address;
					nxt_c.left = i_word_count;
					nxt_c.ctl3 = i_flash_control_word_three;
					nxt_c.st = (i_word_count == WORD_RST) ? ST_PARK : ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (step && fifo_out_valid) begin
					nxt_c.req.addr = c_ff.addr;
					nxt_c.req.data = fifo_out_data;
					nxt_c.wr = 1'b1;
					nxt_c.tmr = CNT_W'(WORD_PROG_TICKS);
					nxt_c.st = ST_PROG;
				end
			end
			ST_PROG: begin
				if (step && c_ff.tmr == '0) begin
					nxt_c.addr = c_ff.addr + ADDR_STEP;
					nxt_c.left = c_ff.left - LAST_WORD;
					nxt_c.st = (c_ff.left == LAST_WORD) ? ST_PARK : ST_FETCH;
				end
			end
			ST_PARK: begin
				// Known resting place; only a new start leaves it.
				if (i_start) begin
					nxt_c.st = ST_IDLE;
				end
			end
			default: begin
				nxt_c.st = ST_IDLE;
			end
		endcase
		// Ready is dropped the moment a word is caught, before its acknowledge leaves.
		nxt_c.rdy = !nxt_c.pend && !fifo_out_valid && !(c_ff.pend && fifo_in_ready);
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			c_ff <= '0;
		end else begin
			c_ff <= nxt_c;
		end
	end

	// Link side: a new word may leave only when the previous one was acknowledged.
	assign link_idle = (l_ff.req == l_ff.ack_sync[1]);
	assign push_word = i_dr_update & i_mailbox_exchange_instruction & l_ff.expect_data;

	always_comb begin
		nxt_l = l_ff;
		nxt_l.ack_sync = {l_ff.ack_sync[0], c_ff.ack};
		nxt_l.rdy_sync = {l_ff.rdy_sync[0], c_ff.rdy};
		if (i_dr_capture && i_mailbox_exchange_instruction) begin
			nxt_l.sr = WORD_RST;
			nxt_l.sr[READY_BIT] = l_ff.rdy_sync[1] & link_idle;
			nxt_l.sr[EXPECT_BIT] = l_ff.expect_data;
		end else if (i_dr_shift) begin
			nxt_l.sr = {i_tdi, l_ff.sr[15:1]};
		end
		if (push_word) begin
			// A word arriving while the last is still in flight is dropped.
			nxt_l.expect_data = 1'b0;
			if (link_idle) begin
				nxt_l.hold = l_ff.sr;
				nxt_l.req = ~l_ff.req;
			end
		end else if (i_dr_update && i_mailbox_exchange_instruction) begin
			nxt_l.expect_data = (l_ff.sr == INPUT_REQUEST);
		end
	end

	always_ff @(posedge i_tck or negedge i_resetn) begin
		if (!i_resetn) begin
			l_ff <= '0;
		end else begin
			l_ff <= nxt_l;
		end
	end

	assign o_tdo = l_ff.sr[0];
	assign o_flash_wr = c_ff.wr;
	assign o_flash_req = c_ff.req;
	assign o_flash_control_word_three = c_ff.ctl3;
	assign o_cpu_clk_en = step;
	assign o_ftg_tick = c_ff.ftg_tick;
	assign o_busy = (c_ff.st == ST_FETCH) || (c_ff.st == ST_PROG);
	assign o_parked = (c_ff.st == ST_PARK);
	assign o_words_left = c_ff.left;

	property p_prog_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		o_flash_wr |-> (c_ff.st == ST_PROG)[*8];
	endproperty
	a_prog_hold: assert property (p_prog_hold) else $error("Word program ended too soon.");

	property p_gated;
		@(posedge i_clk) disable iff (!i_resetn)
		(ctrl_s && !step && c_ff.st != ST_IDLE && c_ff.st != ST_PARK) |=>
			(c_ff.st == $past(c_ff.st)) && $stable(c_ff.left);
	endproperty
	a_gated: assert property (p_gated) else $error("Engine moved without a test clock.");

	property p_free;
		@(posedge i_clk) disable iff (!i_resetn)
		(!ctrl_s && c_ff.st == ST_FETCH && fifo_out_valid) |-> o_cpu_clk_en ##1 o_flash_wr;
	endproperty
	a_free: assert property (p_free) else $error("Free-running engine was stalled.");

	property p_ack;
		@(posedge i_clk) disable iff (!i_resetn)
		(c_ff.pend && fifo_in_ready) |=> $changed(c_ff.ack) && !c_ff.pend;
	endproperty
	a_ack: assert property (p_ack) else $error("Mailbox word not handed on.");

	property p_park;
		@(posedge i_clk) disable iff (!i_resetn)
		(o_parked && !i_start) |=> o_parked && !o_flash_wr;
	endproperty
	a_park: assert property (p_park) else $error("Engine left the parking loop.");

	property p_word_src;
		@(posedge i_clk) disable iff (!i_resetn)
		(fifo_out_valid && fifo_out_ready) |=> o_flash_wr && (o_flash_req.data == $past(fifo_out_data));
	endproperty
	a_word_src: assert property (p_word_src) else $error("Written word not from mailbox.");

	property p_push;
		@(posedge i_tck) disable iff (!i_resetn)
		(push_word && link_idle) |=> $changed(l_ff.req) && (l_ff.hold == $past(l_ff.sr));
	endproperty
	a_push: assert property (p_push) else $error("Mailbox word not posted.");

	property p_ready;
		@(posedge i_tck) disable iff (!i_resetn)
		(i_dr_capture && i_mailbox_exchange_instruction && !link_idle) |=> !l_ff.sr[READY_BIT];
	endproperty
	a_ready: assert property (p_ready) else $error("Ready shown while word in flight.");

	property p_tick;
		@(posedge i_clk) disable iff (!i_resetn)
		o_ftg_tick |=> !o_ftg_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("Timing tick lasted too long.");

	// Under control a finished program still waits for a test clock before moving on.
	property p_wait_step;
		@(posedge i_clk) disable iff (!i_resetn)
		(ctrl_s && c_ff.st == ST_PROG && !step) |=> (c_ff.st == ST_PROG);
	endproperty
	a_wait_step: assert property (p_wait_step) else $error("Program left without a step.");

	// Overrun words are dropped rather than overwriting the word in flight.
	property p_drop;
		@(posedge i_tck) disable iff (!i_resetn)
		(push_word && !link_idle) |=> $stable(l_ff.req) && $stable(l_ff.hold);
	endproperty
	a_drop: assert property (p_drop) else $error("Word in flight was overwritten.");

	c_write: cover property (@(posedge i_clk) disable iff (!i_resetn) o_flash_wr);
	c_park: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_parked));
	c_full: cover property (@(posedge i_clk) disable iff (!i_resetn) c_ff.pend && !fifo_in_ready);
	c_free_write: cover property (@(posedge i_clk) disable iff (!i_resetn)
		!ctrl_s && o_flash_wr);
	c_drop: cover property (@(posedge i_tck) disable iff (!i_resetn)
		push_word && !link_idle);
endmodule // jmfw_mailbox_top

// file: design/jmfw_pkg.sv
// Package for the test-port mailbox flash write block: constants and carriers.
package jmfw_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned FTG_PERIOD_NS = 3000;
	localparam int unsigned FTG_CYC = (FTG_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WORD_PROG_NS = 75000;
	localparam int unsigned WORD_PROG_TICKS = (WORD_PROG_NS + FTG_PERIOD_NS - 1) / FTG_PERIOD_NS;
	localparam int unsigned CNT_W = 5;
	localparam logic [15:0] INPUT_REQUEST = 16'h0001;
	localparam int unsigned READY_BIT = 0;
	localparam int unsigned EXPECT_BIT = 1;
	localparam logic [15:0] ADDR_STEP = 16'h0002;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [15:0] LAST_WORD = 16'h0001;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_PROG, ST_PARK} jmfw_eng_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} jmfw_flash_req_s;

	typedef struct packed {
		jmfw_eng_e st;
		logic [15:0] addr;
		logic [15:0] left;
		logic [15:0] ctl3;
		jmfw_flash_req_s req;
		logic wr;
		logic [CNT_W-1:0] ftg_cnt;
		logic ftg_tick;
		logic [CNT_W-1:0] tmr;
		logic [1:0] ctrl_sync;
		logic [2:0] cpu_test_clock_sync;
		logic [1:0] req_sync;
		logic req_seen;
		logic pend;
		logic [15:0] pend_data;
		logic ack;
		logic rdy;
	} jmfw_core_s;

	typedef struct packed {
		logic [15:0] sr;
		logic [15:0] hold;
		logic expect_data;
		logic req;
		logic [1:0] ack_sync;
		logic [1:0] rdy_sync;
	} jmfw_link_s;
endpackage

// file: design/jmfw_fifo.sv
// Word FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module jmfw_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_resetn,
	// Filling side.
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Draining side.
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} jmfw_fifo_s;

	jmfw_fifo_s r_ff;
	jmfw_fifo_s nxt_r;
	logic push;
	logic pop;

	assign o_in_ready = (r_ff.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (r_ff.cnt != '0);
	assign o_out_data = r_ff.mem[r_ff.rp];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	always_comb begin
		nxt_r = r_ff;
		if (push) begin
			nxt_r.mem[r_ff.wp] = i_in_data;
			nxt_r.wp = r_ff.wp + AW'(1);
		end
		if (pop) begin
			nxt_r.rp = r_ff.rp + AW'(1);
		end
		if (push && !pop) begin
			nxt_r.cnt = r_ff.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			nxt_r.cnt = r_ff.cnt - (AW+1)'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end
endmodule // jmfw_fifo

// file: verification/jmfw_prog_model.sv
// Programmer model that drives test port frames on a gated test clock.
`timescale 1ns/10ps
module jmfw_prog_model (
	// Test port pins.
	output logic o_tck,
	output logic o_tdi,
	output logic o_dr_capture,
	output logic o_dr_shift,
	output logic o_dr_update,
	output logic o_exch,
	input wire logic i_tdo
);
	initial begin
		{o_tck, o_tdi, o_dr_capture, o_dr_shift, o_dr_update, o_exch} = '0;
	end
	// The test clock only runs inside frames and the reset's cyc(4), so idle gaps never clock the link.
	task automatic cyc(input int n);
		repeat (n) begin
			#7.5 o_tck = 1'b1;
			#7.5 o_tck = 1'b0;
		end
	endtask
	task automatic frame(input logic [15:0] v, output logic [15:0] q);
		o_exch = 1'b1;
		o_dr_capture = 1'b1;
		cyc(1);
		q[0] = i_tdo;
		o_dr_capture = 1'b0;
		o_dr_shift = 1'b1;
		for (int i = 0; i < 16; i++) begin
			o_tdi = v[i];
			cyc(1);
			if (i < 15) q[i+1] = i_tdo;
		end
		o_dr_shift = 1'b0;
		// A released data line shows the inverse so a stale bit is never read as good.
		o_tdi = ~o_tdi;
		o_dr_update = 1'b1;
		cyc(1);
		o_dr_update = 1'b0;
	endtask
endmodule // jmfw_prog_model

// file: verification/jtag_mailbox_flash_write_bench.sv
// Self-checking bench for the mailbox flash write block.
`timescale 1ns/10ps
module jtag_mailbox_flash_write_bench;
	import jmfw_pkg::*;
	typedef struct packed {
		logic ctrl;
		logic [15:0] addr;
		logic [15:0] cnt;
		logic [15:0] ctl3;
		logic [15:0] data;
	} jmfw_row_s;
	logic i_clk, i_resetn, tck, tdi, cap, sh, upd, exch, tdo;
	logic ctrl, step, start, wr, clk_en, tick, busy, parked;
	logic [15:0] addr, cnt, ctl3, ctl3_q, left, q;
	jmfw_flash_req_s req;
	jmfw_flash_req_s wq[$];
	int n_fail, tests_run;
	int cycles = 0;
	int ticks = 0;
	jmfw_row_s rows[3] = '{{1'b1, 16'h8000, 16'h0002, 16'hA500, 16'h1234},
		{1'b0, 16'hFFFA, 16'h0003, 16'hA540, 16'hBEEF},
		{1'b0, 16'h4400, 16'h0000, 16'hA500, 16'h0000}};
	jmfw_mailbox_top i_jmfw_mailbox_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_tck(tck),
		.i_tdi(tdi), .i_dr_capture(cap), .i_dr_shift(sh), .i_dr_update(upd),
		.i_mailbox_exchange_instruction(exch), .o_tdo(tdo), .i_under_test_ctrl(ctrl),
		.i_cpu_test_clock(step), .i_start(start), .i_first_write_address(addr),
		.i_word_count(cnt), .i_flash_control_word_three(ctl3), .o_flash_wr(wr),
		.o_flash_req(req), .o_flash_control_word_three(ctl3_q), .o_cpu_clk_en(clk_en),
		.o_ftg_tick(tick), .o_busy(busy), .o_parked(parked), .o_words_left(left));
	jmfw_prog_model i_jmfw_prog_model (.o_tck(tck), .o_tdi(tdi), .o_dr_capture(cap),
		.o_dr_shift(sh), .o_dr_update(upd), .o_exch(exch), .i_tdo(tdo));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic complete_run();
		if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Registered outputs are taken half a cycle after they launch.
	always @(negedge i_clk) begin
		cycles++;
		ticks += int'(tick === 1'b1);
		if (wr === 1'b1) wq.push_back(req);
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic clks(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic go();
		start = 1'b1;
		clks(1);
		start = 1'b0;
	endtask
	task automatic rst();
		i_resetn = 1'b0;
		i_jmfw_prog_model.cyc(4);
		clks(20);
		chk({busy, parked, wr, clk_en, left}, 20'h10000);
		chk(req, 32'h0);
		chk(ctl3_q, 16'h0);
		i_resetn = 1'b1;
		clks(3);
	endtask
	task automatic send(input logic [15:0] d);
		i_jmfw_prog_model.frame(INPUT_REQUEST, q);
		i_jmfw_prog_model.frame(d, q);
		chk(q, 16'h0003);
		i_jmfw_prog_model.frame(16'h0000, q);
		chk(q, 16'h0000);
	endtask
	task automatic run(input jmfw_row_s r);
		int t0;
		wq.delete();
		ctrl = 1'b0;
		{addr, cnt, ctl3} = {r.addr, r.cnt, r.ctl3};
		go();
		ctrl = r.ctrl;
		clks(4);
		for (int k = 0; k < int'(r.cnt); k++) begin
			send(r.data + 16'(k));
			if (r.ctrl) begin
				t0 = ticks;
				clks(300);
				chk(ticks - t0, 10);
				chk(wq.size(), k);
				repeat (30) begin
					step = 1'b1;
					clks(3);
					step = 1'b0;
					clks(27);
				end
			end else begin
				q = 16'h0000;
				for (int n = 0; n < 1000 && q[READY_BIT] !== 1'b1; n++)
					i_jmfw_prog_model.frame(16'h0000, q);
				chk(q[READY_BIT], 1'b1);
			end
		end
		for (int n = 0; n < 2000 && parked !== 1'b1; n++) clks(1);
		clks(50);
		chk({parked, busy, left}, 18'h20000);
		chk(ctl3_q, r.ctl3);
		chk(wq.size(), r.cnt);
		foreach (wq[k]) chk(wq[k], {16'(r.addr + ADDR_STEP * k), 16'(r.data + k)});
		// The target is taken back under control before anything else touches it.
		ctrl = 1'b1;
		go();
		clks(2);
		chk(parked, 1'b0);
	endtask
	initial begin
		{i_resetn, ctrl, step, start, addr, cnt, ctl3} = '0;
		n_fail = 0;
		tests_run = 0;
		rst();
		foreach (rows[i]) run(rows[i]);
		// A reset in mid-run must leave nothing behind for the next run.
		{addr, cnt} = {16'h2000, 16'h0003};
		go();
		send(16'hCAFE);
		rst();
		run(rows[0]);
		complete_run();
	end
endmodule // jtag_mailbox_flash_write_bench
